// ===== hdl/plc_pkg.sv
// shared constants and carrier types for the phy led and collision register bank
package plc_pkg;
	localparam int          CLK_HZ        = 40_000_000;
	localparam int          BASE_TICK_US  = 8000;
	localparam int          BASE_TICK_CYC = CLK_HZ / 1_000_000 * BASE_TICK_US;
	localparam int          ADDR_W        = 8;
	localparam int          LED_N         = 4;
	localparam int          SEL_W         = 4;
	localparam logic [5:0]  IDX_MODE      = 6'h1b;
	localparam logic [5:0]  IDX_FUNC      = 6'h1c;
	localparam logic [5:0]  IDX_BLINK     = 6'h1d;
	localparam logic [5:0]  IDX_LATE      = 6'h1e;
	localparam logic [5:0]  IDX_STAT      = 6'h1f;
	localparam int          MODE_EXT_BIT  = 0;
	localparam int          MODE_LCEN_BIT = 1;
	localparam int          BSET_LSB      = 14;
	localparam int          BDIV_LSB      = 8;
	localparam int          BPAT_LSB      = 0;
	localparam logic [1:0]  BSET_RST      = 2'h0;
	localparam logic [5:0]  BDIV_RST      = 6'h1f;
	localparam logic [7:0]  BPAT_RST      = 8'h55;
	localparam int          LATE_EVEN_LSB = 0;
	localparam int          LATE_ODD_LSB  = 8;
	localparam int          STAT_SEL_BIT  = 15;
	localparam int          STAT_SWAP_BIT = 14;
	localparam int          STAT_POL3_BIT = 13;
	localparam logic [9:0]  LC_B0         = 10'h040;
	localparam logic [9:0]  LC_B1         = 10'h060;
	localparam logic [9:0]  LC_B2         = 10'h080;
	localparam logic [9:0]  LC_B3         = 10'h0c0;
	localparam logic [9:0]  LC_END        = 10'h140;
	localparam logic [7:0]  LC_MAX        = 8'hff;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [3:0]  MD_GIG        = 4'h0;
	localparam logic [3:0]  MD_FAST       = 4'h1;
	localparam logic [3:0]  MD_SLOW       = 4'h2;
	localparam logic [3:0]  MD_GIG_FASTBL = 4'h3;
	localparam logic [3:0]  MD_LINK       = 4'h4;
	localparam logic [3:0]  MD_TX         = 4'h5;
	localparam logic [3:0]  MD_RX         = 4'h6;
	localparam logic [3:0]  MD_ACT        = 4'h7;
	localparam logic [3:0]  MD_FDX        = 4'h8;
	localparam logic [3:0]  MD_COLL       = 4'h9;
	localparam logic [3:0]  MD_LINK_ACTBL = 4'ha;
	localparam logic [3:0]  MD_LINK_RXBL  = 4'hb;
	localparam logic [3:0]  MD_FDX_COLBL  = 4'hc;
	localparam logic [3:0]  MD_BLINK      = 4'hd;
	localparam logic [3:0]  MD_ON         = 4'he;
	localparam logic [3:0]  MD_OFF        = 4'hf;
	localparam logic [3:0]  XMD_SLOW_FAST = 4'h0;

	typedef enum logic [1:0] {
		SPD_10,
		SPD_100,
		SPD_1000
	} plc_speed_t;

	typedef struct packed {
		logic       link_up;
		plc_speed_t speed;
		logic       full_duplex;
		logic       tx_act;
		logic       rx_act;
		logic       collision;
		logic       pair23_swap;
		logic       pair3_pol_inv;
		logic [9:0] tx_byte_cnt;
	} plc_phy_stat_t;
endpackage

// ===== hdl/plc_led_blink.sv
// one led blink pattern shifter with its own frequency divider
`timescale 1ns/1ps
module plc_led_blink (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire logic [5:0] div,
	input  wire logic [7:0] pattern,
	output logic            blink
);
	import plc_pkg::*;

	typedef struct packed {
		logic [5:0] div_cnt;
		logic [2:0] bit_idx;
	} plc_blink_st_t;

	plc_blink_st_t s_q;
	plc_blink_st_t s_d;

	// a shorter divider written mid-count still wraps, since the compare is >=
	always_comb begin
		s_d = s_q;
		if (tick) begin
			if (s_q.div_cnt >= div) begin
				s_d.div_cnt = '0;
				s_d.bit_idx = s_q.bit_idx + 3'h1;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign blink = pattern[s_q.bit_idx];
endmodule

// ===== hdl/plc_late_coll.sv
// four saturating late-collision counters binned by transmit byte position
`timescale 1ns/1ps
module plc_late_coll (
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic            coll,
	input  wire logic            half_duplex,
	input  wire logic [9:0]      byte_idx,
	input  wire logic            count_en,
	input  wire logic            clr,
	output logic [3:0][7:0]      cnt
);
	import plc_pkg::*;

	typedef struct packed {
		logic [3:0][7:0] cnt;
	} plc_lc_st_t;

	plc_lc_st_t s_q;
	plc_lc_st_t s_d;
	logic       sat;
	logic [2:0] bin;

	// bin 4 means early or beyond the window: not counted
	function automatic logic [2:0] lc_bin(input logic [9:0] b);
		if (b < LC_B0 || b >= LC_END) return 3'h4;
		else if (b < LC_B1) return 3'h0;
		else if (b < LC_B2) return 3'h1;
		else if (b < LC_B3) return 3'h2;
		else return 3'h3;
	endfunction

	always_comb begin
		s_d = s_q;
		sat = 1'b0;
		bin = lc_bin(byte_idx);
		for (int i = 0; i < LED_N; i++) begin
			if (s_q.cnt[i] == LC_MAX) sat = 1'b1;
		end
		if (clr) begin
			s_d.cnt = '0;
		end else if (coll && half_duplex && count_en && !sat && !bin[2]) begin
			s_d.cnt[bin[1:0]] = s_q.cnt[bin[1:0]] + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cnt = s_q.cnt;
endmodule

// ===== hdl/plc_phy_led_regs.sv
// phy led control, blink pattern, late-collision and pair status registers over axi4-lite
`timescale 1ns/1ps
module plc_phy_led_regs #(
	parameter int BASE_TICK_CYC = plc_pkg::BASE_TICK_CYC
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [plc_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [plc_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [15:0]                   led_config_strap,
	input  wire plc_pkg::plc_phy_stat_t        phy_stat,
	output logic [plc_pkg::LED_N-1:0]          led_out
);
	import plc_pkg::*;

	localparam int TW = $clog2(BASE_TICK_CYC + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(BASE_TICK_CYC - 1);

	typedef struct packed {
		logic [15:0]              strap_s1;
		logic [15:0]              strap_s2;
		logic                     ext_mode;
		logic                     lc_en;
		logic [15:0]              func_sel;
		logic [1:0]               bset;
		logic [LED_N-1:0][5:0]    bdiv;
		logic [LED_N-1:0][7:0]    bpat;
		logic                     upper_sel;
		logic                     swap;
		logic                     pol3;
		logic [LED_N-1:0]         led;
		logic [TW-1:0]            tick_cnt;
		logic                     aw_ok;
		logic [ADDR_W-1:0]        awaddr;
		logic                     w_ok;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
		logic                     rd_fx;
		logic                     rd_upper;
	} plc_top_st_t;

	plc_top_st_t         s_q;
	plc_top_st_t         s_d;
	logic                tick;
	logic [LED_N-1:0]    blink;
	logic [3:0][7:0]     lc_cnt;
	logic                lc_clr;
	logic                aw_hs;
	logic                w_hs;
	logic                ar_hs;
	logic                do_wr;

	function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction

	// byte lanes 0 and 1 only; the upper half of each register reads as zero
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) r[7:0] = wd[7:0];
		if (st[1]) r[15:8] = wd[15:8];
		return r;
	endfunction

	function automatic logic led_fn(input logic [3:0] sel, input logic ext, input logic bl,
		input plc_phy_stat_t p);
		logic lk;
		logic act;
		lk  = p.link_up;
		act = p.tx_act | p.rx_act;
		if (ext) begin
			// only the first extended code is defined; the rest keep the led dark
			if (sel == XMD_SLOW_FAST) return lk && (p.speed == SPD_10 || p.speed == SPD_100);
			return 1'b0;
		end
		case (sel)
		MD_GIG:        return lk && p.speed == SPD_1000;
		MD_FAST:       return lk && p.speed == SPD_100;
		MD_SLOW:       return lk && p.speed == SPD_10;
		MD_GIG_FASTBL: return lk && (p.speed == SPD_1000 || (p.speed == SPD_100 && bl));
		MD_LINK:       return lk;
		MD_TX:         return p.tx_act;
		MD_RX:         return p.rx_act;
		MD_ACT:        return act;
		MD_FDX:        return lk && p.full_duplex;
		MD_COLL:       return p.collision;
		MD_LINK_ACTBL: return lk && (act ? bl : 1'b1);
		MD_LINK_RXBL:  return lk && (p.rx_act ? bl : 1'b1);
		MD_FDX_COLBL:  return lk && p.full_duplex && (p.collision ? bl : 1'b1);
		MD_BLINK:      return bl;
		MD_ON:         return 1'b1;
		default:       return 1'b0;
		endcase
	endfunction

	assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_ok && !s_q.bvalid;
	// a read is refused while its side effect is still pending, so pairs never skip
	assign s_axi_arready = !s_q.rvalid && !s_q.rd_fx;
	assign aw_hs         = s_axi_awvalid && s_axi_awready;
	assign w_hs          = s_axi_wvalid && s_axi_wready;
	assign ar_hs         = s_axi_arvalid && s_axi_arready;
	assign do_wr         = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
	assign tick          = (s_q.tick_cnt == TICK_LAST);
	assign lc_clr        = s_q.rd_fx && s_q.rd_upper;

	always_comb begin
		logic [15:0] v;
		logic [1:0]  ns;
		s_d = s_q;
		v   = '0;
		ns  = '0;
		s_d.strap_s1 = led_config_strap;
		s_d.strap_s2 = s_q.strap_s1;
		s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TW'(1);
		s_d.swap     = phy_stat.pair23_swap;
		// inversion can only be judged on a gigabit link
		s_d.pol3     = phy_stat.pair3_pol_inv && phy_stat.link_up
			&& phy_stat.speed == SPD_1000;
		for (int i = 0; i < LED_N; i++) begin
			s_d.led[i] = led_fn(s_q.func_sel[i*SEL_W +: SEL_W], s_q.ext_mode, blink[i],
				phy_stat);
		end
		// write address and data are taken in either order
		if (aw_hs) begin
			s_d.aw_ok  = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			s_d.w_ok  = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (do_wr) begin
			s_d.aw_ok  = 1'b0;
			s_d.w_ok   = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			if (s_q.awaddr == reg_addr(IDX_MODE)) begin
				v = merge16({14'h0000, s_q.lc_en, s_q.ext_mode}, s_q.wdata, s_q.wstrb);
				s_d.ext_mode = v[MODE_EXT_BIT];
				s_d.lc_en    = v[MODE_LCEN_BIT];
			end else if (s_q.awaddr == reg_addr(IDX_FUNC)) begin
				s_d.func_sel = merge16(s_q.func_sel, s_q.wdata, s_q.wstrb);
			end else if (s_q.awaddr == reg_addr(IDX_BLINK)) begin
				v = merge16({s_q.bset, s_q.bdiv[s_q.bset], s_q.bpat[s_q.bset]},
					s_q.wdata, s_q.wstrb);
				ns = v[BSET_LSB +: 2];
				// the divider and pattern land in the set named by this same write
				s_d.bset     = ns;
				s_d.bdiv[ns] = v[BDIV_LSB +: 6];
				s_d.bpat[ns] = v[BPAT_LSB +: 8];
			end else if (s_q.awaddr == reg_addr(IDX_LATE) || s_q.awaddr == reg_addr(IDX_STAT)) begin
				s_d.bresp = RESP_OKAY;
			end else begin
				s_d.bresp = RESP_SLVERR;
			end
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// side effects run the cycle after the data was captured
		if (s_q.rd_fx) begin
			s_d.rd_fx     = 1'b0;
			s_d.upper_sel = !s_q.rd_upper;
		end
		if (ar_hs) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			s_d.rdata  = '0;
			if (s_axi_araddr == reg_addr(IDX_MODE)) begin
				s_d.rdata[MODE_EXT_BIT]  = s_q.ext_mode;
				s_d.rdata[MODE_LCEN_BIT] = s_q.lc_en;
			end else if (s_axi_araddr == reg_addr(IDX_FUNC)) begin
				s_d.rdata[15:0] = s_q.func_sel;
			end else if (s_axi_araddr == reg_addr(IDX_BLINK)) begin
				s_d.rdata[15:0] = {s_q.bset, s_q.bdiv[s_q.bset], s_q.bpat[s_q.bset]};
			end else if (s_axi_araddr == reg_addr(IDX_LATE)) begin
				if (s_q.upper_sel) begin
					s_d.rdata[LATE_EVEN_LSB +: 8] = lc_cnt[2];
					s_d.rdata[LATE_ODD_LSB +: 8]  = lc_cnt[3];
				end else begin
					s_d.rdata[LATE_EVEN_LSB +: 8] = lc_cnt[0];
					s_d.rdata[LATE_ODD_LSB +: 8]  = lc_cnt[1];
				end
				s_d.rd_fx    = 1'b1;
				s_d.rd_upper = s_q.upper_sel;
			end else if (s_axi_araddr == reg_addr(IDX_STAT)) begin
				s_d.rdata[STAT_SEL_BIT]  = s_q.upper_sel;
				s_d.rdata[STAT_SWAP_BIT] = s_q.swap;
				s_d.rdata[STAT_POL3_BIT] = s_q.pol3;
			end else begin
				s_d.rresp = RESP_SLVERR;
			end
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	// synchronous reset: selectors load the synchronised strap while reset is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q          <= '0;
			s_q.strap_s1 <= led_config_strap;
			s_q.strap_s2 <= s_q.strap_s1;
			s_q.func_sel <= s_q.strap_s2;
			s_q.bset     <= BSET_RST;
			s_q.bdiv     <= {LED_N{BDIV_RST}};
			s_q.bpat     <= {LED_N{BPAT_RST}};
		end else begin
			s_q <= s_d;
		end
	end

	for (genvar g = 0; g < LED_N; g++) begin : g_blink
		plc_led_blink u_blink (
			.aclk    (aclk),
			.aresetn (aresetn),
			.tick    (tick),
			.div     (s_q.bdiv[g]),
			.pattern (s_q.bpat[g]),
			.blink   (blink[g])
		);
	end

	// counting halts while the upper pair waits to be read
	plc_late_coll u_late (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.coll        (phy_stat.collision),
		.half_duplex (!phy_stat.full_duplex),
		.byte_idx    (phy_stat.tx_byte_cnt),
		.count_en    (s_q.lc_en && !s_q.upper_sel),
		.clr         (lc_clr),
		.cnt         (lc_cnt)
	);

	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp  = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata  = s_q.rdata;
	assign s_axi_rresp  = s_q.rresp;
	assign led_out      = s_q.led;
endmodule

// ===== testbench/plc_phy_led_regs_properties.sv
// concurrent checks of the register bank bus handshake and status bits
`timescale 1ns/1ps
module plc_phy_led_regs_properties
	import plc_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire plc_phy_stat_t     phy_stat
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_unmapped;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00;
	endsequence
	sequence rd_status;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h7c;
	endsequence
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_unmapped_wr: assert property (wr_unmapped |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_swap_status: assert property (rd_status ##0 $stable(phy_stat.pair23_swap)
		|=> s_axi_rdata[STAT_SWAP_BIT] == $past(phy_stat.pair23_swap))
		else $error("pair swap bit wrong");
	a_pol_gig_only: assert property (rd_status ##0 $stable(phy_stat)
		|=> s_axi_rdata[STAT_POL3_BIT] == ($past(phy_stat.pair3_pol_inv)
		&& $past(phy_stat.link_up) && $past(phy_stat.speed) == SPD_1000))
		else $error("pair 3 inversion bit wrong");
endmodule

bind plc_phy_led_regs plc_phy_led_regs_properties u_chk (.*);

// ===== testbench/tb_plc_phy_led_regs.sv
// self-checking bench for the led, blink, late-collision and status registers
`timescale 1ns/1ps
module tb_plc_phy_led_regs;
	import plc_pkg::*;
	logic          aclk = 0, aresetn = 0;
	logic [7:0]    s_axi_awaddr = 0, s_axi_araddr = 0;
	logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic          s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0]   s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]    s_axi_wstrb = 4'h3, led_out;
	logic [1:0]    s_axi_bresp, s_axi_rresp;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [15:0]   led_config_strap = 16'hfed4;
	plc_phy_stat_t phy_stat = '{1'b1, SPD_1000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 10'h0};
	logic [9:0]    bl [9] = '{10'd63, 10'd64, 10'd95, 10'd96, 10'd128, 10'd191, 10'd192,
		10'd319, 10'd320};
	int            error_cnt = 0, n_compared = 0, cyc = 0, k, t;
	logic          prev;

	plc_phy_led_regs #(.BASE_TICK_CYC(4)) uut (.*);

	always #12.5 aclk = ~aclk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		chk("bresp", er, s_axi_bresp);
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
		chk("rresp", er, s_axi_rresp);
		chk("rdata", e, s_axi_rdata);
	endtask

	// same code on all four leds; codes in skip blink and are left out
	task automatic modes(input logic [15:0] on, input logic [15:0] skip);
		for (k = 0; k < 16; k++) begin
			if (!skip[k]) begin
				wr(8'h70, {4{k[3:0]}}, RESP_OKAY);
				repeat (3) @(posedge aclk);
				chk("led_out", {4{on[k]}}, led_out);
			end
		end
	endtask

	task automatic coll(input logic [9:0] b);
		@(posedge aclk);
		phy_stat.collision <= 1;
		phy_stat.tx_byte_cnt <= b;
		@(posedge aclk);
		phy_stat.collision <= 0;
	endtask

	task automatic conclude();
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// the whole run needs under two thousand cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		rd(8'h70, 16'hfed4, RESP_OKAY);
		chk("led_out", 4'b0101, led_out & 4'b1101);
		rd(8'h74, 16'h1f55, RESP_OKAY);
		rd(8'h78, 16'h0000, RESP_OKAY);
		rd(8'h7c, 16'he000, RESP_OKAY);
		rd(8'h78, 16'h0000, RESP_OKAY);
		rd(8'h7c, 16'h6000, RESP_OKAY);
		rd(8'h00, 16'h0000, RESP_SLVERR);
		wr(8'h00, 16'hffff, RESP_SLVERR);
		wr(8'h7c, 16'hffff, RESP_OKAY);
		rd(8'h7c, 16'h6000, RESP_OKAY);
		wr(8'h70, 16'h1234, RESP_OKAY);
		rd(8'h70, 16'h1234, RESP_OKAY);
		modes(16'h5d19, 16'h2000);
		phy_stat.speed <= SPD_100;
		phy_stat.full_duplex <= 0;
		modes(16'h4c12, 16'h2008);
		wr(8'h6c, 16'h0001, RESP_OKAY);
		wr(8'h70, 16'h0000, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("led_out", 4'hf, led_out);
		phy_stat.speed <= SPD_1000;
		repeat (3) @(posedge aclk);
		chk("led_out", 4'h0, led_out);
		coll(10'd64);
		wr(8'h6c, 16'h0000, RESP_OKAY);
		wr(8'h70, 16'hdddd, RESP_OKAY);
		wr(8'h74, 16'h00ff, RESP_OKAY);
		wr(8'h74, 16'h4000, RESP_OKAY);
		rd(8'h74, 16'h4000, RESP_OKAY);
		// old pattern bits can stay up to 128 cycles each
		repeat (200) @(posedge aclk);
		for (t = 0; t < 64; t++) begin
			@(posedge aclk);
			chk("led_blink", 2'b01, led_out[1:0]);
		end
		k = 0;
		prev = led_out[2];
		for (t = 0; t < 640; t++) begin
			@(posedge aclk);
			if (led_out[2] !== prev) k++;
			prev = led_out[2];
		end
		chk("blink_edges", 1, k >= 4 && k <= 6);
		wr(8'h6c, 16'h0002, RESP_OKAY);
		foreach (bl[i]) coll(bl[i]);
		phy_stat.full_duplex <= 1;
		coll(10'd64);
		phy_stat.full_duplex <= 0;
		rd(8'h78, 16'h0102, RESP_OKAY);
		rd(8'h7c, 16'he000, RESP_OKAY);
		coll(10'd96);
		rd(8'h78, 16'h0202, RESP_OKAY);
		rd(8'h7c, 16'h6000, RESP_OKAY);
		rd(8'h78, 16'h0000, RESP_OKAY);
		rd(8'h78, 16'h0000, RESP_OKAY);
		for (t = 0; t < 256; t++) coll(10'd64);
		coll(10'd96);
		rd(8'h78, 16'h00ff, RESP_OKAY);
		rd(8'h78, 16'h0000, RESP_OKAY);
		conclude();
	end
endmodule
